// [hw/csa_pkg.sv]
package csa_pkg;
  // timing figures
  localparam int unsigned CLK_FREQ_HZ = 100_000_000;
  localparam int unsigned BUS_RST_MIN_MS = 1900; // least bus reset time
  localparam int unsigned BUS_RST_MAX_MS = 2100; // longest bus reset time
  localparam int unsigned BUS_RST_CYC = (BUS_RST_MIN_MS + BUS_RST_MAX_MS) / 2 * (CLK_FREQ_HZ / 1000);
  localparam int unsigned FILT_NS = 200;
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned FILT_CYC = (FILT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // 7-bit command address space
  localparam int unsigned CMD_W = 7;
  localparam logic [6:0] CMD_SUBCMD_LO = 7'h3E; // subcommand low byte
  localparam logic [6:0] CMD_SUBCMD_HI = 7'h3F; // subcommand high byte
  localparam logic [6:0] CMD_XFER_BASE = 7'h40; // block transfer window
  localparam logic [6:0] CMD_XFER_LAST = 7'h5F;
  localparam logic [6:0] CMD_STATUS = 7'h00;
  localparam logic [6:0] CMD_SETTING = 7'h01; // selected setting, writable when locked
  localparam logic [6:0] CMD_DMEM = 7'h02;     // data memory word

  // subcommand codes
  localparam logic [15:0] SUB_KEY = 16'h0035;
  localparam logic [15:0] SUB_CFG_ENTER = 16'h0090;
  localparam logic [15:0] SUB_CFG_EXIT = 16'h0092;
  localparam logic [15:0] SUB_ROM_SIG = 16'h0009;
  localparam logic [15:0] SUB_DROM_SIG = 16'h000A;
  localparam logic [15:0] SUB_CFG_SIG = 16'h000B;
  localparam logic [15:0] SUB_SCRATCH = 16'h0050;
  localparam logic [15:0] SUB_OTP_WR = 16'h00A0;
  localparam logic [15:0] SUB_EXTRA = 16'h0060; // extended subcommand

  localparam int unsigned SCR_BYTES = 32;
  localparam logic [7:0] OTP_SCR_BASE = 8'h80; // scratchpad image in otp
  localparam int unsigned NREG = 8;

  typedef enum logic [1:0] {
    LVL_LOCKED = 2'b00,
    LVL_OPENED = 2'b01,
    LVL_UNRESTRICTED = 2'b10
  } csa_level_t;

  typedef enum logic [2:0] {
    ST_LOAD = 3'b000,
    ST_CHECK = 3'b001,
    ST_RUN = 3'b010,
    ST_REWRITE = 3'b011,
    ST_OFF = 3'b100
  } csa_state_t;

  typedef enum logic [1:0] {
    PWR_NORMAL = 2'b00,
    PWR_SLEEP = 2'b01,
    PWR_DEEPEST = 2'b10,
    PWR_OFF = 2'b11
  } csa_pwr_t;

  // one command from the serial front end
  typedef struct packed {
    logic valid;
    logic write;
    logic [6:0] addr;
    logic [7:0] data;
  } csa_cmd_t;

  // answer to the serial front end
  typedef struct packed {
    logic valid;
    logic refused;
    logic [7:0] data;
  } csa_rsp_t;
endpackage : csa_pkg

// [hw/csa_core.sv]
`timescale 1ns/1ps
`default_nettype none
module csa_core
  import csa_pkg::*;
#(
  parameter int unsigned BUS_RST_CYCLES = BUS_RST_CYC,
  parameter int unsigned NUM_REGS = NREG,
  parameter logic [31:0] KEY_OPEN = 32'h0414_3672, // arbitrary value
  parameter logic [31:0] KEY_FULL = 32'hFFFF_FFFF, // arbitrary value
  parameter logic [15:0] ROM_SIG_REF = 16'h5A5A, // arbitrary value
  parameter logic [15:0] CFG_SIG_REF = 16'h0000
) (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire csa_pwr_t pwr_state_i,
  input wire logic spi_cs_n_i,
  input wire logic spi_sclk_i,
  input wire logic i2c_scl_i,
  input wire logic filt_en_i,
  input wire csa_cmd_t cmd_i,
  output var csa_rsp_t rsp_o,
  input wire logic [7:0] otp_data_i,
  output logic [7:0] otp_addr_o,
  output logic otp_wr_o,
  output logic [7:0] otp_wdata_o,
  input wire logic [15:0] irom_sig_i,
  input wire logic [15:0] drom_sig_i,
  output logic spi_bus_reset_o,
  output logic i2c_bus_reset_o,
  output logic spi_cs_n_filt_o,
  output logic spi_sclk_filt_o,
  output logic run_o,
  output logic mem_ok_o,
  output logic sig_err_o,
  output logic cfg_err_o,
  output var csa_level_t level_o
);
  localparam int unsigned CW = $clog2(BUS_RST_CYCLES + 1);
  localparam int unsigned FW = $clog2(FILT_CYC + 1);
  localparam int unsigned RW = $clog2(NUM_REGS); // register index width
  localparam int unsigned XFER_SPAN = int'(CMD_XFER_LAST - CMD_XFER_BASE) + 1;
  localparam bit REGS_OK = NUM_REGS >= 2 && NUM_REGS <= XFER_SPAN
    && (NUM_REGS & (NUM_REGS - 1)) == 0;

  // elaboration checks: index slices need a power of two inside the window
  if (!REGS_OK) begin : g_bad_regs
    $error("csa_core: NUM_REGS must be a power of two within the transfer window");
  end
  if (BUS_RST_CYCLES < 2) begin : g_bad_timer
    $error("csa_core: BUS_RST_CYCLES too small");
  end

  // two-stage synchronisers for pins
  logic [2:0] sync1, sync2;
  always_ff @(posedge sys_clk_i) begin
    sync1 <= {i2c_scl_i, spi_sclk_i, spi_cs_n_i};
    sync2 <= sync1;
  end

  // input filter: levels must hold FILT_CYC cycles when enabled
  logic [FW-1:0] fcnt_cs, fcnt_ck;
  logic cs_f, ck_f;
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      cs_f <= 1'b1;
      ck_f <= 1'b0;
      fcnt_cs <= '0;
      fcnt_ck <= '0;
    end else begin
      if (!filt_en_i || sync2[0] == cs_f) fcnt_cs <= '0;
      else fcnt_cs <= fcnt_cs + 1'b1;
      if (!filt_en_i || fcnt_cs == FW'(FILT_CYC - 1)) cs_f <= sync2[0];
      if (!filt_en_i || sync2[1] == ck_f) fcnt_ck <= '0;
      else fcnt_ck <= fcnt_ck + 1'b1;
      if (!filt_en_i || fcnt_ck == FW'(FILT_CYC - 1)) ck_f <= sync2[1];
    end
  end
  assign spi_cs_n_filt_o = cs_f;
  assign spi_sclk_filt_o = ck_f;

  // bus stall timers
  logic [CW-1:0] spi_cnt, i2c_cnt;
  logic ck_prev;
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      spi_cnt <= '0;
      i2c_cnt <= '0;
      ck_prev <= 1'b0;
      spi_bus_reset_o <= 1'b0;
      i2c_bus_reset_o <= 1'b0;
    end else begin
      ck_prev <= ck_f;
      spi_bus_reset_o <= 1'b0;
      i2c_bus_reset_o <= 1'b0;
      if (cs_f || ck_f != ck_prev) spi_cnt <= '0;
      else if (spi_cnt == CW'(BUS_RST_CYCLES - 1)) begin
        spi_cnt <= '0;
        spi_bus_reset_o <= 1'b1;
      end else spi_cnt <= spi_cnt + 1'b1;
      if (sync2[2]) i2c_cnt <= '0;
      else if (i2c_cnt == CW'(BUS_RST_CYCLES - 1)) begin
        i2c_cnt <= '0;
        i2c_bus_reset_o <= 1'b1;
      end else i2c_cnt <= i2c_cnt + 1'b1;
    end
  end

  // power and configuration sequencing
  csa_state_t state;
  logic [5:0] idx;
  logic [7:0] regs [NUM_REGS];
  logic [7:0] csum;
  logic [7:0] sub_lo;
  logic [15:0] sub_code;
  logic [31:0] key_buf;
  logic [7:0] scratch [SCR_BYTES];
  logic otp_busy;
  logic [4:0] otp_idx;
  logic [7:0] otp_waddr;
  csa_level_t level;

  // subcommand decode for the command being taken
  logic is_sub_hi_wr;
  logic [15:0] cur_sub;
  logic acc_ok;
  assign is_sub_hi_wr = cmd_i.valid && cmd_i.write && cmd_i.addr == CMD_SUBCMD_HI;
  assign cur_sub = {cmd_i.data, sub_lo};

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      state <= ST_LOAD;
      idx <= '0;
      csum <= '0;
      mem_ok_o <= 1'b0;
    end else if (pwr_state_i == PWR_OFF) begin
      state <= ST_OFF;
      idx <= '0;
      csum <= '0; // check starts afresh when power returns
      mem_ok_o <= 1'b0;
    end else begin
      case (state)
        ST_OFF: state <= ST_LOAD; // power returned
        ST_LOAD: begin
          if (idx == 6'(NUM_REGS - 1)) begin
            idx <= '0;
            state <= ST_CHECK;
          end else idx <= idx + 1'b1;
        end
        ST_CHECK: begin
          csum <= csum ^ regs[idx[$clog2(NUM_REGS)-1:0]];
          if (idx == 6'(NUM_REGS - 1)) begin
            mem_ok_o <= 1'b1;
            state <= ST_RUN;
          end else idx <= idx + 1'b1;
        end
        ST_RUN: begin
          if (is_sub_hi_wr && cur_sub == SUB_CFG_ENTER && level == LVL_UNRESTRICTED)
            state <= ST_REWRITE;
        end
        ST_REWRITE: begin
          if (is_sub_hi_wr && cur_sub == SUB_CFG_EXIT) state <= ST_RUN;
        end
        default: state <= ST_LOAD;
      endcase
    end
  end
  assign run_o = (state == ST_RUN);
  // write address travels with its byte, load index otherwise
  assign otp_addr_o = otp_wr_o ? otp_waddr : 8'(idx);
  assign level_o = level;

  // register file: loaded from otp, held in low power, cleared at off
  always_ff @(posedge sys_clk_i) begin
    if (state == ST_OFF) begin
      for (int i = 0; i < NUM_REGS; i++) regs[i] <= 8'h00;
    end else if (state == ST_LOAD) begin
      regs[idx[$clog2(NUM_REGS)-1:0]] <= otp_data_i;
    end else if (cmd_i.valid && cmd_i.write && acc_ok && cmd_i.addr >= CMD_XFER_BASE
                 && cmd_i.addr < CMD_XFER_BASE + 7'(NUM_REGS) && sub_code != SUB_SCRATCH) begin
      regs[RW'(cmd_i.addr - CMD_XFER_BASE)] <= cmd_i.data;
    end else if (cmd_i.valid && cmd_i.write && acc_ok && cmd_i.addr == CMD_DMEM) begin
      regs[1] <= cmd_i.data;
    end else if (cmd_i.valid && cmd_i.write && cmd_i.addr == CMD_SETTING) begin
      regs[0] <= cmd_i.data;
    end
  end

  // access check per level
  always_comb begin
    acc_ok = 1'b1;
    if (cmd_i.addr == CMD_DMEM && level == LVL_LOCKED) acc_ok = 1'b0;
    else if (cmd_i.addr >= CMD_XFER_BASE && cmd_i.write && level == LVL_LOCKED)
      acc_ok = 1'b0;
    else if (cmd_i.addr >= CMD_XFER_BASE && cmd_i.write && sub_code == SUB_SCRATCH
             && level != LVL_UNRESTRICTED) acc_ok = 1'b0;
    else if (is_sub_hi_wr && (cur_sub == SUB_EXTRA) && level == LVL_LOCKED) acc_ok = 1'b0;
    else if (is_sub_hi_wr && cur_sub == SUB_OTP_WR && level != LVL_UNRESTRICTED)
      acc_ok = 1'b0;
  end

  // subcommand address, key sequence and level
  always_ff @(posedge sys_clk_i) begin
    if (reset_i || state == ST_OFF) begin
      sub_lo <= '0;
      sub_code <= '0;
      key_buf <= '0;
      level <= LVL_LOCKED;
    end else if (cmd_i.valid && cmd_i.write) begin
      if (cmd_i.addr == CMD_SUBCMD_LO) sub_lo <= cmd_i.data;
      else if (is_sub_hi_wr && acc_ok) begin
        sub_code <= cur_sub;
        if (cur_sub == SUB_KEY) begin
          // key set arrives as the last four transfer bytes
          if (level == LVL_LOCKED && key_buf == KEY_OPEN) level <= LVL_OPENED;
          else if (level == LVL_OPENED && key_buf == KEY_FULL)
            level <= LVL_UNRESTRICTED;
          // mismatch leaves level unchanged
          key_buf <= '0;
        end
      end else if (cmd_i.addr >= CMD_XFER_BASE) begin
        key_buf <= {key_buf[23:0], cmd_i.data};
      end
    end
  end

  // scratchpad and otp programming of it
  always_ff @(posedge sys_clk_i) begin
    if (reset_i || state == ST_OFF) begin
      otp_busy <= 1'b0; // power off aborts programming before the reload
      otp_idx <= '0;
      otp_wr_o <= 1'b0;
      otp_wdata_o <= '0;
      otp_waddr <= '0;
    end else begin
      otp_wr_o <= 1'b0;
      if (cmd_i.valid && cmd_i.write && acc_ok && sub_code == SUB_SCRATCH
          && cmd_i.addr >= CMD_XFER_BASE && cmd_i.addr <= CMD_XFER_LAST)
        scratch[5'(cmd_i.addr - CMD_XFER_BASE)] <= cmd_i.data;
      // whole scratchpad copied, one byte a cycle
      if (otp_busy) begin
        otp_wr_o <= 1'b1;
        otp_wdata_o <= scratch[otp_idx];
        otp_waddr <= OTP_SCR_BASE + 8'(otp_idx);
        otp_idx <= otp_idx + 1'b1;
        if (otp_idx == 5'(SCR_BYTES - 1)) otp_busy <= 1'b0;
      end
      if (is_sub_hi_wr && acc_ok && cur_sub == SUB_OTP_WR) begin
        otp_busy <= 1'b1;
        otp_idx <= '0;
      end
    end
  end

  // signature checks
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      sig_err_o <= 1'b0;
      cfg_err_o <= 1'b0;
    end else if (is_sub_hi_wr && acc_ok) begin
      if (cur_sub == SUB_ROM_SIG) sig_err_o <= irom_sig_i != ROM_SIG_REF;
      if (cur_sub == SUB_DROM_SIG) sig_err_o <= drom_sig_i != ROM_SIG_REF;
      if (cur_sub == SUB_CFG_SIG)
        cfg_err_o <= {8'h00, csum ^ regs[1]} != CFG_SIG_REF;
    end
  end

  // answer to each command
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      rsp_o <= '0;
    end else begin
      rsp_o.valid <= cmd_i.valid;
      rsp_o.refused <= cmd_i.valid && (!acc_ok || state == ST_LOAD || state == ST_CHECK);
      rsp_o.data <= 8'h00;
      if (cmd_i.valid && !cmd_i.write) begin
        if (cmd_i.addr == CMD_STATUS)
          rsp_o.data <= {1'b0, sig_err_o, cfg_err_o, mem_ok_o, run_o, state == ST_REWRITE, level};
        else if (cmd_i.addr == CMD_SETTING) rsp_o.data <= regs[0];
        else if (cmd_i.addr == CMD_DMEM && acc_ok) rsp_o.data <= regs[1];
        else if (cmd_i.addr >= CMD_XFER_BASE && sub_code == SUB_SCRATCH)
          rsp_o.data <= scratch[5'(cmd_i.addr - CMD_XFER_BASE)];
        else if (cmd_i.addr >= CMD_XFER_BASE && cmd_i.addr < CMD_XFER_BASE + 7'(NUM_REGS))
          rsp_o.data <= regs[RW'(cmd_i.addr - CMD_XFER_BASE)];
      end
    end
  end
endmodule : csa_core
`default_nettype wire

// [verification/csa_core_sva.sv]
`timescale 1ns/1ps
`default_nettype none
module csa_core_sva
  import csa_pkg::*;
#(
  parameter int unsigned BUS_RST_CYCLES = 50
) (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire csa_pwr_t pwr_state_i,
  input wire logic spi_cs_n_i,
  input wire logic spi_sclk_i,
  input wire logic i2c_scl_i,
  input wire csa_cmd_t cmd_i,
  input wire csa_rsp_t rsp_o,
  input wire logic otp_wr_o,
  input wire logic spi_bus_reset_o,
  input wire logic i2c_bus_reset_o,
  input wire logic run_o,
  input wire csa_level_t level_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);
  int unsigned spi_cnt;
  int unsigned i2c_cnt;
  logic sclk_q;
  // quiet time on the raw pins, ahead of the synchronisers
  always_ff @(posedge sys_clk_i) begin
    sclk_q <= spi_sclk_i;
    spi_cnt <= (spi_cs_n_i || spi_sclk_i != sclk_q) ? '0 : spi_cnt + 1;
    i2c_cnt <= i2c_scl_i ? '0 : i2c_cnt + 1;
  end
  chk_cmd_answer: assert property (cmd_i.valid |=> rsp_o.valid)
    else $error("command not answered");
  chk_no_stray: assert property (!cmd_i.valid |=> !rsp_o.valid)
    else $error("answer without command");
  chk_dmem_locked: assert property (cmd_i.valid && cmd_i.addr == CMD_DMEM
    && level_o == LVL_LOCKED |=> rsp_o.refused) else $error("locked memory access taken");
  chk_setting_open: assert property (cmd_i.valid && cmd_i.write
    && cmd_i.addr == CMD_SETTING && run_o |=> !rsp_o.refused) else $error("setting refused");
  chk_level_hold: assert property (disable iff (reset_i || pwr_state_i == PWR_OFF)
    !(cmd_i.valid && cmd_i.write && cmd_i.addr == CMD_SUBCMD_HI) |=> $stable(level_o))
    else $error("level moved without subcommand");
  chk_level_step: assert property (level_o == LVL_UNRESTRICTED
    |-> $past(level_o) != LVL_LOCKED) else $error("level skipped opened");
  chk_otp_level: assert property (otp_wr_o |-> level_o == LVL_UNRESTRICTED)
    else $error("otp written below unrestricted");
  chk_boot_check: assert property ($fell(reset_i) |-> !run_o [*8])
    else $error("run before memory check");
  chk_spi_quiet: assert property (spi_bus_reset_o |-> spi_cnt >= BUS_RST_CYCLES)
    else $error("spi bus reset too early");
  chk_i2c_quiet: assert property (i2c_bus_reset_o |-> i2c_cnt >= BUS_RST_CYCLES)
    else $error("i2c bus reset too early");
endmodule : csa_core_sva
bind csa_core csa_core_sva #(.BUS_RST_CYCLES(BUS_RST_CYCLES)) csa_core_sva_inst (
  .sys_clk_i, .reset_i, .pwr_state_i, .spi_cs_n_i, .spi_sclk_i, .i2c_scl_i, .cmd_i,
  .rsp_o, .otp_wr_o, .spi_bus_reset_o, .i2c_bus_reset_o, .run_o, .level_o);
`default_nettype wire

// [verification/csa_otp_model.sv]
`timescale 1ns/1ps
`default_nettype none
module csa_otp_model (
  input wire logic sys_clk_i,
  input wire logic [7:0] addr_i,
  input wire logic wr_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] data_o
);
  logic [7:0] mem [256];
  // programmed settings, read without delay
  initial for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'hA5;
  assign data_o = mem[addr_i];
  // one byte programmed a pulse
  always @(posedge sys_clk_i) if (wr_i === 1'b1) mem[addr_i] <= wdata_i;
endmodule : csa_otp_model
`default_nettype wire

// [verification/config_security_access_bench.sv]
`timescale 1ns/1ps
`default_nettype none
module config_security_access_bench import csa_pkg::*;;
  localparam int unsigned RST = 50;
  localparam logic [31:0] KO = 32'h1234_5678; // arbitrary value
  localparam logic [31:0] KF = 32'h8765_4321; // arbitrary value
  localparam logic [15:0] SIG = 16'h5A5A; // arbitrary value
  // otp image bytes 0-7 xor to zero and byte 1 is A4, so the stored signature is A4
  localparam logic [15:0] CFG = 16'h00A4;
  localparam logic [17:0] OK = 18'h20000;
  localparam logic [17:0] NO = 18'h30000;
  localparam logic [17:0] ANY = 18'h00000;
  logic sys_clk_i = 1'b0, reset_i = 1'b1, spi_cs_n_i = 1'b1, i2c_scl_i = 1'b1;
  logic spi_sclk_i = 1'b0;
  csa_pwr_t pwr_state_i = PWR_NORMAL;
  csa_cmd_t cmd_i = '0;
  logic [15:0] sig_in [2] = '{SIG, SIG};
  csa_rsp_t rsp_o;
  csa_level_t level_o;
  logic [7:0] otp_data_i, otp_addr_o, otp_wdata_o, rnd = 8'h13;
  logic otp_wr_o, spi_bus_reset_o, i2c_bus_reset_o, run_o, mem_ok_o, sig_err_o;
  logic spi_cs_n_filt_o, spi_sclk_filt_o, cfg_err_o;
  logic [17:0] me;
  int errors = 0, n_tests = 0;
  logic [17:0] exp_q [$];
  csa_core #(.BUS_RST_CYCLES(RST), .KEY_OPEN(KO), .KEY_FULL(KF), .ROM_SIG_REF(SIG),
    .CFG_SIG_REF(CFG)) csa_core_inst (.sys_clk_i, .reset_i, .pwr_state_i, .spi_cs_n_i,
    .spi_sclk_i, .i2c_scl_i, .filt_en_i(1'b1), .cmd_i, .rsp_o, .otp_data_i, .otp_addr_o,
    .otp_wr_o, .otp_wdata_o, .irom_sig_i(sig_in[0]), .drom_sig_i(sig_in[1]),
    .spi_bus_reset_o, .i2c_bus_reset_o, .spi_cs_n_filt_o, .spi_sclk_filt_o, .run_o,
    .mem_ok_o, .sig_err_o, .cfg_err_o, .level_o);
  csa_otp_model csa_otp_model_inst (.sys_clk_i, .addr_i(otp_addr_o), .wr_i(otp_wr_o),
    .wdata_i(otp_wdata_o), .data_o(otp_data_i));
  always #5 sys_clk_i = ~sys_clk_i;
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr
  task automatic chk(input string s, input logic [15:0] v, input logic [15:0] e);
    n_tests++;
    if (v !== e) begin
      errors++;
      $display("BAD %s expected %h seen %h", s, e, v);
    end
  endtask : chk
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : end_sim
  // one request, an idle cycle after it; the answer is noted first
  task automatic cmd(input logic w, input logic [6:0] a, input logic [7:0] d,
    input logic [17:0] e);
    exp_q.push_back(e);
    cmd_i = {1'b1, w, a, d};
    @(posedge sys_clk_i) #1;
    cmd_i = '0;
    @(posedge sys_clk_i) #1;
  endtask : cmd
  task automatic sub(input logic [15:0] c, input logic [17:0] e);
    cmd(1'b1, CMD_SUBCMD_LO, c[7:0], ANY);
    cmd(1'b1, CMD_SUBCMD_HI, c[15:8], e);
  endtask : sub
  task automatic key(input logic [31:0] k);
    for (int i = 0; i < 4; i++) cmd(1'b1, CMD_XFER_BASE + 7'(i), k[31 - 8 * i -: 8], ANY);
    sub(SUB_KEY, ANY);
  endtask : key
  // bounded wait for run, spi reset, i2c reset or otp pulse
  task automatic wt(input int sel, input int n, output int c);
    logic [3:0] v;
    for (c = 0; c < n; c++) begin
      @(posedge sys_clk_i) #1;
      v = {otp_wr_o, i2c_bus_reset_o, spi_bus_reset_o, run_o};
      if (v[sel] === 1'b1) return;
    end
    errors++;
    $display("BAD wait %0d expected 1 seen 0", sel);
    end_sim();
  endtask : wt
  // each answer against the oldest note
  always @(posedge sys_clk_i) begin
    if (rsp_o.valid === 1'b1) begin
      chk("answers", 16'(exp_q.size() != 0), 16'h1);
      me = exp_q.size() != 0 ? exp_q.pop_front() : NO;
      if (me[17]) chk("refused", 16'(rsp_o.refused), 16'(me[16]));
      chk("data", 16'(rsp_o.data & me[15:8]), 16'(me[7:0]));
    end
  end
  initial begin
    int c;
    logic hit;
    repeat (12) @(posedge sys_clk_i);
    #1 reset_i = 1'b0;
    cmd(1'b0, CMD_STATUS, 8'h00, NO);
    wt(0, 100, c);
    chk("mem_ok", 16'(mem_ok_o), 16'h1);
    cmd(1'b1, CMD_DMEM, rnd, NO);
    cmd(1'b0, CMD_DMEM, 8'h00, NO);
    cmd(1'b1, CMD_SETTING, rnd, OK);
    sub(SUB_EXTRA, NO);
    rnd = lfsr(rnd);
    key(KO ^ 32'(rnd | 8'h01));
    chk("level", 16'(level_o), 16'(LVL_LOCKED));
    key(KF);
    chk("level", 16'(level_o), 16'(LVL_LOCKED));
    key(KO);
    chk("level", 16'(level_o), 16'(LVL_OPENED));
    $display("test locked done");
    cmd(1'b0, CMD_DMEM, 8'h00, {2'b10, 8'hFF, 8'hA4});
    cmd(1'b1, CMD_DMEM, rnd, OK);
    cmd(1'b0, CMD_DMEM, 8'h00, {2'b10, 8'hFF, rnd});
    sub(SUB_EXTRA, OK);
    sub(SUB_OTP_WR, NO);
    sub(SUB_CFG_ENTER, ANY);
    chk("run", 16'(run_o), 16'h1);
    sub(SUB_SCRATCH, ANY);
    cmd(1'b1, 7'h41, rnd, NO);
    key(KF);
    chk("level", 16'(level_o), 16'(LVL_UNRESTRICTED));
    sub(SUB_SCRATCH, ANY);
    cmd(1'b1, 7'h41, rnd, OK);
    cmd(1'b0, 7'h41, 8'h00, {2'b00, 8'hFF, rnd});
    sub(SUB_OTP_WR, OK);
    wt(3, 50, c);
    chk("otp_addr", 16'(otp_addr_o), 16'(OTP_SCR_BASE + 8'h01));
    chk("otp_data", 16'(otp_wdata_o), 16'(rnd));
    sub(SUB_CFG_ENTER, OK);
    chk("run", 16'(run_o), 16'h0);
    sub(SUB_CFG_EXIT, ANY);
    wt(0, 100, c);
    $display("test unrestricted done");
    pwr_state_i = PWR_SLEEP;
    repeat (4) @(posedge sys_clk_i) #1;
    pwr_state_i = PWR_DEEPEST;
    repeat (4) @(posedge sys_clk_i) #1;
    pwr_state_i = PWR_NORMAL;
    chk("level", 16'(level_o), 16'(LVL_UNRESTRICTED));
    cmd(1'b0, CMD_SETTING, 8'h00, {2'b10, 8'hFF, 8'h13});
    pwr_state_i = PWR_OFF;
    repeat (4) @(posedge sys_clk_i) #1;
    pwr_state_i = PWR_NORMAL;
    chk("level", 16'(level_o), 16'(LVL_LOCKED));
    wt(0, 100, c);
    cmd(1'b0, CMD_SETTING, 8'h00, {2'b10, 8'hFF, 8'hA5});
    cmd(1'b1, CMD_SETTING, rnd, OK);
    cmd(1'b0, CMD_SETTING, 8'h00, {2'b10, 8'hFF, rnd});
    for (int i = 0; i < 2; i++) begin
      sig_in[i] = SIG ^ 16'(rnd | 8'h01);
      sub(i == 0 ? SUB_ROM_SIG : SUB_DROM_SIG, ANY);
      chk("sig_err", 16'(sig_err_o), 16'h1);
      sig_in[i] = SIG;
      sub(i == 0 ? SUB_ROM_SIG : SUB_DROM_SIG, ANY);
      chk("sig_err", 16'(sig_err_o), 16'h0);
    end
    sub(SUB_CFG_SIG, ANY);
    chk("cfg_err", 16'(cfg_err_o), 16'h0);
    key(KO);
    cmd(1'b1, CMD_DMEM, rnd, OK);
    sub(SUB_CFG_SIG, ANY);
    chk("cfg_err", 16'(cfg_err_o), 16'h1);
    cmd(1'b0, CMD_STATUS, 8'h00, {2'b10, 8'hFF, 8'h39});
    // pulse shorter than the filter window never reaches the filtered pin
    spi_sclk_i = 1'b1;
    repeat (5) @(posedge sys_clk_i) #1;
    chk("sclk_filt", 16'(spi_sclk_filt_o), 16'h0);
    spi_sclk_i = 1'b0;
    repeat (25) @(posedge sys_clk_i) #1;
    // select low, clock moving every 40 cycles: no stall yet
    spi_cs_n_i = 1'b0;
    hit = 1'b0;
    for (int i = 0; i < 160; i++) begin
      if (i % 40 == 39) spi_sclk_i = ~spi_sclk_i;
      @(posedge sys_clk_i) #1;
      hit = hit | spi_bus_reset_o;
    end
    chk("spi_early", 16'(hit), 16'h0);
    chk("cs_filt", 16'(spi_cs_n_filt_o), 16'h0);
    chk("sclk_filt", 16'(spi_sclk_filt_o), 16'h1);
    wt(1, 4 * RST, c);
    chk("spi_gap", 16'(c >= RST - 1), 16'h1);
    spi_cs_n_i = 1'b1;
    i2c_scl_i = 1'b0;
    wt(2, 4 * RST, c);
    chk("i2c_gap", 16'(c >= RST - 1), 16'h1);
    i2c_scl_i = 1'b1;
    $display("test power and pins done");
    repeat (3) @(posedge sys_clk_i) #1;
    end_sim();
  end
endmodule : config_security_access_bench
`default_nettype wire
